// >>> design/halfword_stack_map.vh
// register offsets, instruction fields, kinds and cycle figures for the halfword/stack unit
`ifndef HALFWORD_STACK_MAP_VH
`define HALFWORD_STACK_MAP_VH

// register bus byte offsets
`define OFF_CTRL        8'h00
`define OFF_INSTR       8'h04
`define OFF_FLAGS       8'h0c
`define OFF_CYCLES      8'h10
`define REGS_HI         7
`define REGS_LO         6
`define REGS_SEL        2'h1
`define REGS_IDX_HI     5
`define REGS_IDX_LO     2

// control and status bits
`define CTRL_START      0
`define STAT_BUSY       0
`define STAT_DONE       1
`define STAT_ILLEGAL    2
`define FLAGS_BYTE      3
`define FLAGS_MASK      32'hf000_0000

// bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// instruction fields
`define OPC_HI          15
`define OPC_LO          12
`define OPC_HALF        4'h8
`define OPC_SPREL       4'h9
`define OPC_ADDR        4'ha
`define OPC_MISC        4'hb
`define DIR_BIT         11
`define MISC_HI         11
`define MISC_LO         8
`define MISC_ADJ        4'h0
`define PP_HI           10
`define PP_LO           9
`define PP_TAG          2'h2
`define OPT_BIT         8
`define SIGN_BIT        7

// decoded instruction kinds
`define K_ILLEGAL       4'h0
`define K_HW_ST         4'h1
`define K_HW_LD         4'h2
`define K_SP_ST         4'h3
`define K_SP_LD         4'h4
`define K_ADR_PC        4'h5
`define K_ADR_SP        4'h6
`define K_SP_ADJ        4'h7
`define K_PUSH          4'h8
`define K_POP           4'h9

// core register indices
`define RIDX_SP         4'hd
`define RIDX_LR         4'he
`define RIDX_PC         4'hf

// cycle counts of the full-width equivalents
`define CYC_ALU         5'h1
`define CYC_LOAD        5'h3
`define CYC_STORE       5'h2
`define CYC_MST_EXTRA   5'h1
`define CYC_MLD_EXTRA   5'h2
`define CYC_PC_EXTRA    5'h2

// addressing
`define WORD_STEP       32'h0000_0004
`define PC_AHEAD        32'h0000_0004
`define PC_ALIGN_MASK   32'hffff_fffd
`define STRB_LO         4'h3
`define STRB_HI         4'hc
`define STRB_WORD       4'hf

`endif

// >>> design/halfword_stack_decode.v
// field decoder for the halfword, stack-relative, address, stack-adjust and push/pop forms
`timescale 1ns/1ps
`include "halfword_stack_map.vh"
module halfword_stack_decode (
  // instruction in
  input  wire [15:0] instr,
  // decoded fields
  output reg  [3:0]  kind,
  output reg  [2:0]  rd,
  output reg  [2:0]  base_reg,
  output reg  [9:0]  scaled_offset,
  output reg         adj_sub,
  output reg  [8:0]  reg_list,
  output reg  [3:0]  list_count
);
  integer i;

  always @* begin
    kind          = `K_ILLEGAL;
    rd            = instr[2:0];
    base_reg      = instr[5:3];
    scaled_offset = 10'h0;
    adj_sub       = 1'b0;
    reg_list      = 9'h0;
    case (instr[`OPC_HI:`OPC_LO])
      `OPC_HALF: begin
        kind          = instr[`DIR_BIT] ? `K_HW_LD : `K_HW_ST;
        // halfword_scaled_offset counts halfwords
        scaled_offset = {4'h0, instr[10:6], 1'b0};
      end
      `OPC_SPREL: begin
        kind          = instr[`DIR_BIT] ? `K_SP_LD : `K_SP_ST;
        rd            = instr[10:8];
        scaled_offset = {instr[7:0], 2'h0};
      end
      `OPC_ADDR: begin
        kind          = instr[`DIR_BIT] ? `K_ADR_SP : `K_ADR_PC;
        rd            = instr[10:8];
        scaled_offset = {instr[7:0], 2'h0};
      end
      `OPC_MISC: begin
        if (instr[`MISC_HI:`MISC_LO] == `MISC_ADJ) begin
          kind          = `K_SP_ADJ;
          // signed_stack_adjust is sign and magnitude, magnitude in words
          adj_sub       = instr[`SIGN_BIT];
          scaled_offset = {1'b0, instr[6:0], 2'h0};
        end else if (instr[`PP_HI:`PP_LO] == `PP_TAG) begin
          kind     = instr[`DIR_BIT] ? `K_POP : `K_PUSH;
          // only low registers, plus link or program counter option
          reg_list = {instr[`OPT_BIT], instr[7:0]};
        end
      end
      default: kind = `K_ILLEGAL;
    endcase
  end

  always @* begin
    list_count = 4'h0;
    for (i = 0; i < 9; i = i + 1) begin
      list_count = list_count + {3'h0, reg_list[i]};
    end
  end
endmodule

// >>> design/halfword_stack_unit.v
// execute unit for compact halfword, stack-relative, address, stack-adjust and push/pop forms
`timescale 1ns/1ps
`include "halfword_stack_map.vh"
module halfword_stack_unit #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // register bus write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // register bus write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // register bus write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // register bus read
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // data memory
  output wire              mem_valid,
  input  wire              mem_ready,
  output reg               mem_write,
  output reg  [31:0]       mem_addr,
  output reg  [31:0]       mem_wdata,
  output reg  [3:0]        mem_strb,
  input  wire [31:0]       mem_rdata
);
  localparam ST_IDLE = 4'h1;
  localparam ST_EXEC = 4'h2;
  localparam ST_MEM  = 4'h4;
  localparam ST_PAD  = 4'h8;

  reg [31:0]       core [0:15];
  reg [15:0]       instr;
  reg [31:0]       program_status_flags;
  reg [3:0]        state;
  reg [4:0]        cyc;
  reg [4:0]        last_cycles;
  reg              done_flag;
  reg              illegal_flag;
  reg [8:0]        rest;
  reg [3:0]        cur_reg;
  reg [31:0]       sp_final;
  reg [4:0]        target;
  reg [ADDR_W-1:0] aw_addr;
  reg              aw_held;
  reg [31:0]       w_data;
  reg [3:0]        w_strb;
  reg              w_held;
  reg [31:0]       rd_value;
  reg              rd_hit;
  reg              wr_hit;
  integer          k;

  wire [3:0]  kind;
  wire [2:0]  rd;
  wire [2:0]  base_reg;
  wire [9:0]  scaled_offset;
  wire        adj_sub;
  wire [8:0]  reg_list;
  wire [3:0]  list_count;

  wire busy      = (state != ST_IDLE);
  wire wr_commit = aw_held & w_held & ~s_axi_bvalid;
  wire wr_regs   = (aw_addr[`REGS_HI:`REGS_LO] == `REGS_SEL);
  wire start_req = wr_commit & (aw_addr == `OFF_CTRL) & w_strb[0] & w_data[`CTRL_START];
  wire is_pop    = (kind == `K_POP);
  wire is_multi  = (kind == `K_PUSH) | is_pop;
  wire fin_ok    = (cyc >= target);
  wire [31:0] sp_now   = core[`RIDX_SP];
  wire [31:0] list_len = {26'h0, list_count, 2'h0};
  wire [31:0] off_ext  = {22'h0, scaled_offset};
  // halfword address; the decoder has already scaled the offset
  wire [31:0] hw_ea    = core[{1'b0, base_reg}] + off_ext;
  // full descending: lowest address is the first slot of the push
  wire [31:0] push_base = sp_now - list_len;
  wire [31:0] pc_src    = (core[`RIDX_PC] + `PC_AHEAD) & `PC_ALIGN_MASK;
  wire [15:0] half_in   = mem_addr[1] ? mem_rdata[31:16] : mem_rdata[15:0];
  wire [8:0]  rest_next = rest & (rest - 9'h1);

  halfword_stack_decode u_decode (
    .instr         (instr),
    .kind          (kind),
    .rd            (rd),
    .base_reg      (base_reg),
    .scaled_offset (scaled_offset),
    .adj_sub       (adj_sub),
    .reg_list      (reg_list),
    .list_count    (list_count)
  );

  // lowest listed register; bit 8 is lr for push, pc for pop
  function [3:0] first_idx;
    input [8:0] l;
    input       pop;
    integer     j;
    begin
      first_idx = 4'h0;
      for (j = 8; j >= 0; j = j - 1) begin
        if (l[j]) begin
          first_idx = (j == 8) ? (pop ? `RIDX_PC : `RIDX_LR) : j[3:0];
        end
      end
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  strb;
    integer      b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = val[b*8 +: 8];
        end
      end
    end
  endfunction

  wire [31:0] next_instr = merge({16'h0, instr}, w_data, w_strb & `STRB_LO);

  // busy length of the equivalent full-width instruction
  always @* begin
    case (kind)
      `K_HW_ST, `K_SP_ST: target = `CYC_STORE;
      `K_HW_LD, `K_SP_LD: target = `CYC_LOAD;
      `K_PUSH:            target = {1'b0, list_count} + `CYC_MST_EXTRA;
      `K_POP:             target = {1'b0, list_count} + `CYC_MLD_EXTRA
                                   + (reg_list[8] ? `CYC_PC_EXTRA : 5'h0);
      default:            target = `CYC_ALU;
    endcase
  end

  assign mem_valid     = (state == ST_MEM);
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    wr_hit = (aw_addr == `OFF_CTRL) | (aw_addr == `OFF_INSTR) | (aw_addr == `OFF_FLAGS)
             | (aw_addr == `OFF_CYCLES) | wr_regs;
    rd_hit   = 1'b1;
    rd_value = 32'h0;
    if (s_axi_araddr[`REGS_HI:`REGS_LO] == `REGS_SEL) begin
      rd_value = core[s_axi_araddr[`REGS_IDX_HI:`REGS_IDX_LO]];
    end else begin
      case (s_axi_araddr)
        `OFF_CTRL: begin
          rd_value[`STAT_BUSY]    = busy;
          rd_value[`STAT_DONE]    = done_flag;
          rd_value[`STAT_ILLEGAL] = illegal_flag;
        end
        `OFF_INSTR:  rd_value = {16'h0, instr};
        `OFF_FLAGS:  rd_value = program_status_flags;
        `OFF_CYCLES: rd_value = {27'h0, last_cycles};
        default:     rd_hit   = 1'b0;
      endcase
    end
  end

  // bus handshakes; address and data may arrive in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      aw_addr      <= {ADDR_W{1'b0}};
      w_held       <= 1'b0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_commit) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_value;
        s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // software writes and instruction execution; software may not touch
  // the instruction or core registers mid-instruction
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (k = 0; k < 16; k = k + 1) begin
        core[k] <= 32'h0;
      end
      instr                <= 16'h0;
      program_status_flags <= 32'h0;
      state                <= ST_IDLE;
      cyc                  <= 5'h0;
      last_cycles          <= 5'h0;
      done_flag            <= 1'b0;
      illegal_flag         <= 1'b0;
      rest                 <= 9'h0;
      cur_reg              <= 4'h0;
      sp_final             <= 32'h0;
      mem_write            <= 1'b0;
      mem_addr             <= 32'h0;
      mem_wdata            <= 32'h0;
      mem_strb             <= 4'h0;
    end else begin
      if (wr_commit && !busy) begin
        if (wr_regs) begin
          core[aw_addr[`REGS_IDX_HI:`REGS_IDX_LO]] <=
            merge(core[aw_addr[`REGS_IDX_HI:`REGS_IDX_LO]], w_data, w_strb);
        end else if (aw_addr == `OFF_INSTR) begin
          instr <= next_instr[15:0];
        end
      end
      // flags belong to software only; no instruction here writes them
      if (wr_commit && aw_addr == `OFF_FLAGS && w_strb[`FLAGS_BYTE]) begin
        program_status_flags <= w_data & `FLAGS_MASK;
      end
      if (busy) begin
        cyc <= cyc + 5'h1;
      end
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            state        <= ST_EXEC;
            cyc          <= 5'h1;
            done_flag    <= 1'b0;
            illegal_flag <= 1'b0;
          end
        end
        ST_EXEC: begin
          rest    <= 9'h0;
          cur_reg <= {1'b0, rd};
          case (kind)
            `K_HW_ST, `K_HW_LD: begin
              mem_addr  <= hw_ea;
              mem_write <= (kind == `K_HW_ST);
              mem_strb  <= hw_ea[1] ? `STRB_HI : `STRB_LO;
              mem_wdata <= {2{core[{1'b0, rd}][15:0]}};
              state     <= ST_MEM;
            end
            `K_SP_ST, `K_SP_LD: begin
              mem_addr  <= sp_now + off_ext;
              mem_write <= (kind == `K_SP_ST);
              mem_strb  <= `STRB_WORD;
              mem_wdata <= core[{1'b0, rd}];
              state     <= ST_MEM;
            end
            `K_PUSH, `K_POP: begin
              if (reg_list == 9'h0) begin
                illegal_flag <= 1'b1;
              end else begin
                // lr stored even with an empty low list
                cur_reg   <= first_idx(reg_list, is_pop);
                rest      <= reg_list & (reg_list - 9'h1);
                mem_addr  <= is_pop ? sp_now : push_base;
                sp_final  <= is_pop ? sp_now + list_len : push_base;
                mem_write <= ~is_pop;
                mem_strb  <= `STRB_WORD;
                mem_wdata <= core[first_idx(reg_list, 1'b0)];
                state     <= ST_MEM;
              end
            end
            `K_ADR_PC: core[{1'b0, rd}] <= pc_src + off_ext;
            `K_ADR_SP: core[{1'b0, rd}] <= sp_now + off_ext;
            `K_SP_ADJ: core[`RIDX_SP]   <= adj_sub ? sp_now - off_ext
                                                   : sp_now + off_ext;
            default:   illegal_flag <= 1'b1;
          endcase
          if (!(kind == `K_HW_ST || kind == `K_HW_LD || kind == `K_SP_ST ||
                kind == `K_SP_LD || (is_multi && reg_list != 9'h0))) begin
            state       <= fin_ok ? ST_IDLE : ST_PAD;
            done_flag   <= fin_ok;
            last_cycles <= cyc;
          end
        end
        ST_MEM: begin
          if (mem_ready) begin
            if (!mem_write) begin
              if (kind == `K_HW_LD) begin
                core[cur_reg] <= {16'h0, half_in};
              end else begin
                core[cur_reg] <= mem_rdata;
              end
            end
            if (rest == 9'h0) begin
              if (is_multi) begin
                core[`RIDX_SP] <= sp_final;
              end
              state       <= fin_ok ? ST_IDLE : ST_PAD;
              done_flag   <= fin_ok;
              last_cycles <= cyc;
            end else begin
              // ascending addresses, lowest register first
              cur_reg   <= first_idx(rest, is_pop);
              rest      <= rest_next;
              mem_addr  <= mem_addr + `WORD_STEP;
              mem_wdata <= core[first_idx(rest, 1'b0)];
            end
          end
        end
        ST_PAD: begin
          // idle cycles so timing matches the full-width form
          if (fin_ok) begin
            state       <= ST_IDLE;
            done_flag   <= 1'b1;
            last_cycles <= cyc;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// >>> testbench/halfword_stack_monitor.sv
// port checker for the halfword/stack execute unit
`timescale 1ns/1ps
`include "halfword_stack_map.vh"
module halfword_stack_monitor #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire              aclk,
  input wire              aresetn,
  // register bus
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire [31:0]       s_axi_wdata,
  input wire              s_axi_wvalid,
  input wire              s_axi_wready,
  input wire              s_axi_bvalid,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire              s_axi_rvalid,
  // data memory
  input wire              mem_valid,
  input wire              mem_ready,
  input wire              mem_write,
  input wire [31:0]       mem_addr,
  input wire [31:0]       mem_wdata,
  input wire [3:0]        mem_strb
);
  reg  [15:0] ins;
  wire        aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire        mdone = mem_valid && mem_ready;
  // only valid while the bench never rewrites the word during a run
  always @(posedge aclk) begin
    if (!aresetn)
      ins <= 16'h0;
    else if (aw_w && s_axi_awaddr == `OFF_INSTR)
      ins <= s_axi_wdata[15:0];
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  mem_hold_a: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr)
    && $stable(mem_write) && $stable(mem_wdata) && $stable(mem_strb))
    else $error("memory request changed while waiting");
  hw_lane_a: assert property (ins[15:12] == `OPC_HALF && mem_valid && mem_write |->
    mem_strb == (mem_addr[1] ? `STRB_HI : `STRB_LO) && mem_wdata[31:16] == mem_wdata[15:0])
    else $error("halfword store lane wrong");
  sp_word_a: assert property (ins[15:12] == `OPC_SPREL && mem_valid && mem_write |->
    mem_strb == `STRB_WORD) else $error("stack store not a full word");
  no_access_a: assert property ((ins[15:12] == `OPC_ADDR
    || ins[15:8] == {`OPC_MISC, `MISC_ADJ}) |-> !mem_valid) else $error("stray memory access");
  stack_dir_a: assert property (ins[15:12] == `OPC_MISC && mem_valid |->
    mem_write != ins[11]) else $error("push or pop direction wrong");
  ascend_a: assert property (mdone ##1 mdone |->
    mem_addr == $past(mem_addr) + `WORD_STEP) else $error("list addresses not ascending");
  read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // address and data are registered first, so the answer stands two edges later
  write_ans_a: assert property (aw_w |-> ##2 s_axi_bvalid) else $error("write answer late");
endmodule
bind halfword_stack_unit halfword_stack_monitor #(.ADDR_W(ADDR_W)) mon (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .mem_valid, .mem_ready,
  .mem_write, .mem_addr, .mem_wdata, .mem_strb);

// >>> testbench/data_mem_model.sv
// data memory model on the far side of the execute unit
`timescale 1ns/1ps
module data_mem_model (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // wait control
  input  wire        slow,
  // memory port
  input  wire        mem_valid,
  output wire        mem_ready,
  input  wire        mem_write,
  input  wire [31:0] mem_addr,
  input  wire [31:0] mem_wdata,
  input  wire [3:0]  mem_strb,
  output wire [31:0] mem_rdata
);
  // 1 KB that wraps on address bits 9:2
  reg     [31:0] ram [0:255];
  reg            rdy;
  reg     [31:0] junk;
  integer        b;
  assign mem_ready = rdy;
  // outside a read the lines flip each cycle so no stale word passes
  assign mem_rdata = (mem_valid && !mem_write) ? ram[mem_addr[9:2]] : junk;
  always @(posedge aclk) begin
    junk <= aresetn ? ~junk : 32'h5a5a_a5a5;
    rdy <= aresetn && (slow ? !rdy : 1'b1);
    if (aresetn && mem_valid && rdy && mem_write)
      for (b = 0; b < 4; b = b + 1)
        if (mem_strb[b])
          ram[mem_addr[9:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
  end
endmodule

// >>> testbench/compact_isa_halfword_stack_ops_test.sv
// self-checking bench for the halfword/stack execute unit
`timescale 1ns/1ps
`include "halfword_stack_map.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module compact_isa_halfword_stack_ops_test;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        slow = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         mem_valid, mem_ready, mem_write;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
  wire  [3:0]  mem_strb;
  logic [31:0] r [16];
  logic [31:0] m [256];
  logic [7:0]  touched [$];
  logic [1:0]  resp;
  int          errors = 0;
  int          checks = 0;
  int          seed = 76;
  int          ncyc = 0;
  logic [15:0] tab [20] = '{16'h87ca, 16'h883c, 16'h8843, 16'h94ff, 16'h997b, 16'ha28f,
    16'haeff, 16'hb07f, 16'hb0ff, 16'hb09a, 16'hb501, 16'hb5ff, 16'hbdff, 16'hb500,
    16'hbd00, 16'hbc44, 16'hb400, 16'hbc00, 16'h0000, 16'hb100};
  always #10 aclk = ~aclk;
  halfword_stack_unit #(.ADDR_W(8)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_valid, .mem_ready,
    .mem_write, .mem_addr, .mem_wdata, .mem_strb, .mem_rdata);
  data_mem_model far (.aclk, .aresetn, .slow, .mem_valid, .mem_ready, .mem_write, .mem_addr,
    .mem_wdata, .mem_strb, .mem_rdata);
  task automatic conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge aclk) begin
    ncyc++;
    if (ncyc == 30000) begin
      errors++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic model(input logic [15:0] ins, output int cyc, output bit ill);
    logic [31:0] a;
    logic [31:0] w;
    int n;
    int k;
    int idx;
    ill = 1'b0;
    cyc = 1;
    n = $countones(ins[8:0]);
    case (ins[15:12])
      `OPC_HALF: begin
        a = r[ins[5:3]] + {ins[10:6], 1'b0};
        w = m[a[9:2]];
        touched.push_back(a[9:2]);
        cyc = ins[11] ? 3 : 2;
        if (ins[11])
          r[ins[2:0]] = {16'h0, a[1] ? w[31:16] : w[15:0]};
        else if (a[1])
          m[a[9:2]][31:16] = r[ins[2:0]][15:0];
        else
          m[a[9:2]][15:0] = r[ins[2:0]][15:0];
      end
      `OPC_SPREL: begin
        a = r[13] + {ins[7:0], 2'b00};
        touched.push_back(a[9:2]);
        cyc = ins[11] ? 3 : 2;
        if (ins[11])
          r[ins[10:8]] = m[a[9:2]];
        else
          m[a[9:2]] = r[ins[10:8]];
      end
      `OPC_ADDR:
        r[ins[10:8]] = (ins[11] ? r[13] : (r[15] + 4) & 32'hffff_fffd)
          + {ins[7:0], 2'b00};
      `OPC_MISC:
        if (ins[11:8] == `MISC_ADJ)
          r[13] = ins[7] ? r[13] - {ins[6:0], 2'b00} : r[13] + {ins[6:0], 2'b00};
        else if (ins[10:9] != `PP_TAG || n == 0)
          ill = 1'b1;
        else begin
          a = ins[11] ? r[13] : r[13] - 4 * n;
          for (k = 0; k < 9; k++)
            if (ins[k]) begin
              idx = k < 8 ? k : (ins[11] ? 15 : 14);
              touched.push_back(a[9:2]);
              if (ins[11])
                r[idx] = m[a[9:2]];
              else
                m[a[9:2]] = r[idx];
              a = a + 4;
            end
          r[13] = ins[11] ? a : r[13] - 4 * n;
          cyc = ins[11] ? n + 2 + 2 * ins[8] : n + 1;
        end
      default: ill = 1'b1;
    endcase
  endtask
  task automatic exec(input logic [15:0] ins);
    logic [31:0] v;
    int cyc;
    bit ill;
    int k;
    touched.delete();
    wr(`OFF_INSTR, {16'h0, ins});
    wr(`OFF_CTRL, 32'h1);
    k = 0;
    do begin
      rd(`OFF_CTRL, v);
      k++;
    end while (v[`STAT_BUSY] !== 1'b0 && k < 100);
    model(ins, cyc, ill);
    `CHK(v[`STAT_ILLEGAL], ill)
    if (!ill) `CHK(v[`STAT_DONE], 1'b1)
    rd(`OFF_CYCLES, v);
    if (!ill && !slow) `CHK(v, 32'(cyc))
    rd(`OFF_FLAGS, v);
    `CHK(v, `FLAGS_MASK)
    for (k = 0; k < 16; k++) begin
      rd(8'h40 + 8'(4 * k), v);
      if (k < 15 || ins[15:8] == 8'hbd) `CHK(v, r[k])
    end
    foreach (touched[j]) `CHK(far.ram[touched[j]], m[touched[j]])
  endtask
  task automatic load_regs;
    int k;
    for (k = 0; k < 16; k++) begin
      r[k] = $random(seed);
      if (k == 15) r[k][0] = 1'b0;
      wr(8'h40 + 8'(4 * k), r[k]);
    end
  endtask
  initial begin
    int k;
    logic [31:0] v;
    logic [15:0] ins;
    for (k = 0; k < 256; k++) begin
      m[k] = $random(seed);
      far.ram[k] = m[k];
    end
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_CTRL, v);
    `CHK(v, 32'h0)
    rd(8'h08, v);
    `CHK({resp, v}, {`RESP_SLVERR, 32'h0})
    wr(8'h20, 32'h1);
    `CHK(resp, `RESP_SLVERR)
    wr(`OFF_FLAGS, 32'hffff_ffff);
    $display("bus test done");
    load_regs();
    for (k = 0; k < 20; k++) exec(tab[k]);
    $display("directed test done");
    for (k = 0; k < 40; k++) begin
      if (k % 10 == 0) load_regs();
      ins = 16'($random(seed));
      ins[15:14] = 2'b10;
      if (ins[15:12] == `OPC_MISC) begin
        if (ins[0]) ins[11:8] = `MISC_ADJ;
        else ins[10:9] = `PP_TAG;
      end
      slow <= 1'($random(seed));
      exec(ins);
    end
    $display("random test done");
    conclude();
  end
endmodule
